// file: verilog/transfer_sw_activation_regs.svh
// Purpose: Register map constants for the software activation block
// Assumes: 32-bit AXI4-Lite, one aligned word per register
// Notes:   Offsets are register indices; byte address is index times four
`ifndef TRANSFER_SW_ACTIVATION_REGS_SVH
`define TRANSFER_SW_ACTIVATION_REGS_SVH

// Register indices
`define VECTOR_REG_INDEX  16'hFF37
`define STATUS_REG_INDEX  16'hFF80

// Vector register fields
`define ENABLE_BIT        7
`define VECTOR_MSB        6
`define VECTOR_LSB        0
`define VECTOR_REG_RESET  8'h00

// Status register fields
`define STAT_REQ_BIT      0
`define STAT_BUSY_BIT     1
`define STAT_ARMED_BIT    2
`define STAT_SELECT_BIT   3
`define STAT_EXHAUST_BIT  4

// Bus answers
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// file: verilog/transfer_sw_activation_pkg.sv
// Purpose: Shared types and address decode for the activation block
// Assumes: Register constants come from the _regs header
// Notes:   Decode is used by both the read and the write path
`default_nettype none
`include "transfer_sw_activation_regs.svh"

package transfer_sw_activation_pkg;

    // Vector number carried to the transfer controller
    typedef logic [`VECTOR_MSB:`VECTOR_LSB] vector_type;

    // Which register a bus access selects
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_VECTOR,
        SEL_STATUS
    } reg_sel_type;

    // Word index to register selection
    function automatic reg_sel_type decodeSel(input logic [15:0] wordIndex);
        reg_sel_type sel;
        sel = SEL_NONE;
        if (wordIndex == `VECTOR_REG_INDEX) begin
            sel = SEL_VECTOR;
        end else if (wordIndex == `STATUS_REG_INDEX) begin
            sel = SEL_STATUS;
        end
        return sel;
    endfunction

endpackage

`default_nettype wire

// file: verilog/activation_req_hold.sv
// Purpose: Holds the activation request until the controller takes it
// Assumes: Raise and take are one-cycle pulses on mclk
// Notes:   A raise in the take cycle keeps the request up
`default_nettype none

module activation_req_hold (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic raise,
    input  wire logic take,
    output var  logic req
);

    // Request flag, raise wins over take
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            req <= 1'b0;
        end else if (raise) begin
            req <= 1'b1;
        end else if (take) begin
            req <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// file: verilog/axil_word_slave.sv
// Purpose: Minimal AXI4-Lite slave, one write and one read in flight
// Assumes: Parent decodes the address and supplies read data and hits
// Notes:   Write strobe pulse comes once both address and data are held
`default_nettype none
`include "transfer_sw_activation_regs.svh"

module axil_word_slave #(
    parameter int AW = 18
) (
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic [AW-1:0] awaddr,
    input  wire logic          awvalid,
    output var  logic          awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output var  logic          wready,
    output var  logic [1:0]    bresp,
    output var  logic          bvalid,
    input  wire logic          bready,
    input  wire logic [AW-1:0] araddr,
    input  wire logic          arvalid,
    output var  logic          arready,
    output var  logic [31:0]   rdata,
    output var  logic [1:0]    rresp,
    output var  logic          rvalid,
    input  wire logic          rready,
    output var  logic          wrPulse,
    output var  logic [AW-1:0] wrAddr,
    output var  logic [31:0]   wrData,
    output var  logic [3:0]    wrStrb,
    input  wire logic          wrHit,
    output var  logic          rdPulse,
    input  wire logic [31:0]   rdDataIn,
    input  wire logic          rdHit
);

    // Both halves held and no answer pending
    assign wrPulse = !awready && !wready && !bvalid;
    // Read is decoded in the handshake cycle
    assign rdPulse = arvalid && arready;

    // Write address channel
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awready <= 1'b1;
            wrAddr  <= '0;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            wrAddr  <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wready <= 1'b1;
            wrData <= '0;
            wrStrb <= '0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            wrData <= wdata;
            wrStrb <= wstrb;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp  <= `RESP_OKAY;
        end else if (wrPulse) begin
            bvalid <= 1'b1;
            bresp  <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read channel, data captured at the address handshake
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `RESP_OKAY;
        end else if (rdPulse) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rdDataIn;
            rresp   <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// file: verilog/transfer_sw_activation.sv
// Purpose: Software activation register for the data transfer controller
// Assumes: Controller status inputs are synchronous to mclk
// Notes:   Vector register at index FF37, status register at index FF80
//          Bus offsets are word indices, the byte address is four times that
//          Enable priority: software set, then hardware clear, then software clear
//          The status word is read-only; writes to it are answered and dropped
//          Address bits above the map must be zero for a hit
//
// The AXI4-Lite slave port was decided locally.
`default_nettype none
`include "transfer_sw_activation_regs.svh"

module transfer_sw_activation #(
    parameter int AW = 18
) (
    // Clock and reset
    input  wire logic                                  mclk,
    input  wire logic                                  rst_n,
    // AXI4-Lite write address
    input  wire logic [AW-1:0]                         awaddr,
    input  wire logic                                  awvalid,
    output var  logic                                  awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                           wdata,
    input  wire logic [3:0]                            wstrb,
    input  wire logic                                  wvalid,
    output var  logic                                  wready,
    // AXI4-Lite write response
    output var  logic [1:0]                            bresp,
    output var  logic                                  bvalid,
    input  wire logic                                  bready,
    // AXI4-Lite read address
    input  wire logic [AW-1:0]                         araddr,
    input  wire logic                                  arvalid,
    output var  logic                                  arready,
    // AXI4-Lite read data
    output var  logic [31:0]                           rdata,
    output var  logic [1:0]                            rresp,
    output var  logic                                  rvalid,
    input  wire logic                                  rready,
    // Transfer controller side
    input  wire logic                                  irqAfterTransferSelect,
    input  wire logic                                  countExhausted,
    input  wire logic                                  transferBusy,
    input  wire logic                                  transferDone,
    input  wire logic                                  activationTake,
    output var  logic                                  activationReq,
    output var  logic                                  swActivationEnable,
    output var  transfer_sw_activation_pkg::vector_type swVectorNumber
);

    // Types and the shared register decode
    import transfer_sw_activation_pkg::*;

    // Write strobe from the bus slave
    logic          wrPulse;
    // Held write address
    logic [AW-1:0] wrAddr;
    // Held write data
    logic [31:0]   wrData;
    // Held write byte strobes
    logic [3:0]    wrStrb;
    // Read handshake pulse
    logic          rdPulse;
    // Read data offered to the slave
    logic [31:0]   rdDataIn;
    // Register selected by the write
    reg_sel_type   wrSel;
    // Register selected by the read
    reg_sel_type   rdSel;
    // Write reaches a mapped register
    logic          wrHit;
    // Read reaches a mapped register
    logic          rdHit;
    // Write into the low byte of the vector register
    logic          vecWrite;
    // Software asks for enable set
    logic          swSet;
    // Software asks for enable clear
    logic          swClear;
    // Hardware clear at end of a transfer
    logic          hwClear;
    // Enable was read as one since the last write
    logic          clearArmed;
    // Enable rises from software
    logic          raiseReq;
    // Next enable value
    logic          next_enable;
    // Write address has no bits set above the map
    logic          wrUpperClear;
    // Read address has no bits set above the map
    logic          rdUpperClear;

    // The slave keeps address, data and strobes until the response
    // is taken, so every write decode below works from steady copies and
    // a slow master cannot change a write half way through
    // Bus slave with held address and data
    axil_word_slave #(
        .AW       (AW)
    ) u_slave (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .awaddr   (awaddr),
        .awvalid  (awvalid),
        .awready  (awready),
        .wdata    (wdata),
        .wstrb    (wstrb),
        .wvalid   (wvalid),
        .wready   (wready),
        .bresp    (bresp),
        .bvalid   (bvalid),
        .bready   (bready),
        .araddr   (araddr),
        .arvalid  (arvalid),
        .arready  (arready),
        .rdata    (rdata),
        .rresp    (rresp),
        .rvalid   (rvalid),
        .rready   (rready),
        .wrPulse  (wrPulse),
        .wrAddr   (wrAddr),
        .wrData   (wrData),
        .wrStrb   (wrStrb),
        .wrHit    (wrHit),
        .rdPulse  (rdPulse),
        .rdDataIn (rdDataIn),
        .rdHit    (rdHit)
    );

    // Upper address bits beyond the word index, checked only when present
    generate
        if (AW > 18) begin : g_wide_addr
            // Any bit set above the map turns the access into a miss
            assign wrUpperClear = (wrAddr[AW-1:18] == '0);
            assign rdUpperClear = (araddr[AW-1:18] == '0);
        end else begin : g_narrow_addr
            // No bits above the index, nothing to check
            assign wrUpperClear = 1'b1;
            assign rdUpperClear = 1'b1;
        end
    endgenerate

    // Address decode, word index from byte address
    always_comb begin
        // Byte lanes below the word are ignored
        wrSel = decodeSel(wrAddr[17:2]);
        rdSel = decodeSel(araddr[17:2]);
        // A miss above the map overrides the index decode
        if (!wrUpperClear) begin
            wrSel = SEL_NONE;
        end
        if (!rdUpperClear) begin
            rdSel = SEL_NONE;
        end
    end

    // A miss still gets an answer, so software never hangs on a bad
    // offset; it only learns of the slip from the response code
    // Hits report OKAY, misses SLVERR
    assign wrHit = (wrSel != SEL_NONE);
    assign rdHit = (rdSel != SEL_NONE);

    // Upper lanes carry nothing; a write with lane 0 off is answered
    // but leaves every bit of the register alone
    // Only the low byte lane carries this register
    assign vecWrite = wrPulse && (wrSel == SEL_VECTOR) && wrStrb[0];

    // The slave captures this word at the read handshake, so the
    // status flags show the state of that very cycle
    // Read data selection
    always_comb begin
        rdDataIn = 32'h0000_0000;
        case (rdSel)
            // Enable and vector number
            SEL_VECTOR: begin
                rdDataIn[`ENABLE_BIT]             = swActivationEnable;
                rdDataIn[`VECTOR_MSB:`VECTOR_LSB] = swVectorNumber;
            end
            // Live controller and request state
            SEL_STATUS: begin
                // Bits above the status flags stay zero
                rdDataIn[`STAT_REQ_BIT]     = activationReq;
                rdDataIn[`STAT_BUSY_BIT]    = transferBusy;
                rdDataIn[`STAT_ARMED_BIT]   = clearArmed;
                rdDataIn[`STAT_SELECT_BIT]  = irqAfterTransferSelect;
                rdDataIn[`STAT_EXHAUST_BIT] = countExhausted;
            end
            // Unmapped reads as zero
            default: begin
                rdDataIn = 32'h0000_0000;
            end
        endcase
    end

    // The field has no side effects; software may rewrite it at any
    // time, and the request logic simply uses whatever it holds
    // Vector number field, plain read and write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            // Field clears to zero on reset
            swVectorNumber <= vector_type'(`VECTOR_REG_RESET);
        end else if (vecWrite) begin
            // A strobed write replaces all seven bits
            swVectorNumber <= wrData[`VECTOR_MSB:`VECTOR_LSB];
        end
    end

    // A one is taken whatever the bit holds now, so software can
    // always re-arm the controller without reading first
    // Software set takes whatever the bit holds
    assign swSet = vecWrite && wrData[`ENABLE_BIT];

    // A zero only lands after a read of one, so a stale write of zero
    // cannot cancel an activation that software has not yet seen;
    // a running transfer also keeps the bit, whatever was read
    // Software clear needs a read of one first, and no transfer running
    assign swClear = vecWrite && !wrData[`ENABLE_BIT] && clearArmed
                     && !transferBusy;

    // The controller reports the end of a software transfer; with the
    // select low and count left, the bit drops so the next software
    // start needs a fresh write of one
    // Hardware clear only with select low and count remaining
    assign hwClear = transferDone && !irqAfterTransferSelect
                     && !countExhausted;

    // One priority order for every source: a set in the same cycle as a
    // clear wins, so a late write of one is never lost to the hardware
    // end of the previous transfer
    // Enable next value, set wins over either clear
    always_comb begin
        next_enable = swActivationEnable;
        if (swSet) begin
            // Software write of one
            next_enable = 1'b1;
        end else if (hwClear) begin
            // End of a transfer with count left
            next_enable = 1'b0;
        end else if (swClear) begin
            // Armed write of zero while idle
            next_enable = 1'b0;
        end
        // Select high or count out leaves the bit as it is
        // A busy controller blocks only the software clear
    end

    // The bit changes at the same edge that raises the write response,
    // so a read issued after the response always sees the new value
    // Enable flag register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            // Disabled after reset
            swActivationEnable <= 1'b0;
        end else begin
            // Follows the priority logic above
            swActivationEnable <= next_enable;
        end
    end

    // The arm remembers that software has seen the bit high; any later
    // write to the register with lane 0 strobed, or the bit dropping, makes a new read
    // necessary before a zero is taken again
    // Arming for a later write of zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            // Nothing read yet after reset
            clearArmed <= 1'b0;
        end else if (rdPulse && rdSel == SEL_VECTOR && swActivationEnable) begin
            // A read that sees enable high arms the clear
            clearArmed <= 1'b1;
        end else if (vecWrite || !next_enable) begin
            // A write with lane 0 strobed, or the bit dropping, disarms
            clearArmed <= 1'b0;
        end
    end

    // Only a rise from zero starts the controller; rewriting a one while
    // the bit is already set leaves any pending request as it is
    // Request on a software rise of enable
    assign raiseReq = swSet && !swActivationEnable;

    // The request stays up until the controller accepts it, so a take
    // pulse that comes late still finds it; a raise in the take cycle
    // wins, so a new start is never swallowed by the old take
    // Request held until the controller takes it
    activation_req_hold u_req (
        .mclk  (mclk),
        .rst_n (rst_n),
        .raise (raiseReq),
        .take  (activationTake),
        .req   (activationReq)
    );

endmodule

`default_nettype wire

// file: dv/transfer_sw_activation_monitor.sv
// Purpose: Port-level checks on the software activation block
// Assumes: One mclk domain, rst_n asynchronous active low
// Notes:   A write lands when both readies are low and no response waits
`default_nettype none

module transfer_sw_activation_monitor (
    input wire logic                                  mclk,
    input wire logic                                  rst_n,
    input wire logic                                  awready,
    input wire logic                                  wready,
    input wire logic                                  bvalid,
    input wire logic                                  rvalid,
    input wire logic                                  rready,
    input wire logic [31:0]                           rdata,
    input wire logic                                  irqAfterTransferSelect,
    input wire logic                                  countExhausted,
    input wire logic                                  transferBusy,
    input wire logic                                  transferDone,
    input wire logic                                  activationTake,
    input wire logic                                  activationReq,
    input wire logic                                  swActivationEnable,
    input wire transfer_sw_activation_pkg::vector_type swVectorNumber
);
    import transfer_sw_activation_pkg::*;

    wire logic land = !awready && !wready && !bvalid; // Register write next edge
    logic      seenOne;                               // Enable read back as one

    // Tracks a read of the enable as one until the next write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seenOne <= 1'b0;
        end else if (land) begin
            seenOne <= 1'b0;
        end else if (rvalid && rready && rdata[7]) begin
            seenOne <= 1'b1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_vec_only_write: assert property (!land |=> $stable(swVectorNumber))
        else $error("vector changed without a write");
    a_set_by_write: assert property ($rose(swActivationEnable) |-> $past(land))
        else $error("enable rose without a write");
    a_clear_after_read: assert property ($fell(swActivationEnable) && !$past(transferDone)
        |-> $past(seenOne) && $past(land))
        else $error("enable cleared without prior read of one");
    a_hw_clear: assert property (transferDone && !irqAfterTransferSelect && !countExhausted
        && !land |=> !swActivationEnable)
        else $error("enable not cleared after transfer");
    a_keep_select: assert property (swActivationEnable && transferDone && irqAfterTransferSelect
        && !land |=> swActivationEnable)
        else $error("enable lost with select high");
    a_keep_exhaust: assert property (swActivationEnable && transferDone && countExhausted
        && !land |=> swActivationEnable)
        else $error("enable lost with count exhausted");
    a_keep_busy: assert property (swActivationEnable && transferBusy && !transferDone
        |=> swActivationEnable)
        else $error("enable lost during transfer");
    a_req_on_set: assert property ($rose(swActivationEnable) |-> activationReq)
        else $error("no request after enable rise");
    a_req_needs_set: assert property ($rose(activationReq) |-> $rose(swActivationEnable))
        else $error("request rose without enable rise");
    a_req_take: assert property (activationReq && activationTake && !land
        |=> !activationReq)
        else $error("request stayed after take");
    a_write_answer: assert property (land |=> bvalid)
        else $error("write response late");
    a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");

    c_sw_clear: cover property ($fell(swActivationEnable) && !$past(transferDone));
    c_hw_clear: cover property ($fell(swActivationEnable) && $past(transferDone));
    c_take: cover property ($fell(activationReq));
endmodule

bind transfer_sw_activation transfer_sw_activation_monitor u_transfer_sw_activation_monitor (
    .mclk, .rst_n, .awready, .wready, .bvalid, .rvalid, .rready, .rdata,
    .irqAfterTransferSelect, .countExhausted, .transferBusy, .transferDone,
    .activationTake, .activationReq, .swActivationEnable, .swVectorNumber
);

`default_nettype wire

// file: dv/test_transfer_sw_activation.sv
// Purpose: Directed bench for the software activation block
// Assumes: AXI4-Lite master with bready and rready held high
// Notes:   Each task returns just after a rising edge
`default_nettype none

module test_transfer_sw_activation;
    timeunit 1ns;
    timeprecision 1ps;
    import transfer_sw_activation_pkg::*;

    localparam logic [17:0] VEC = 18'h3FCDC; // Vector register byte address
    localparam logic [17:0] BAD = 18'h00010; // Unmapped address
    localparam logic [17:0] STAT = 18'h3FE00; // Status register byte address
    logic        mclk = 1'b0, rst_n = 1'b0;
    logic [17:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = '0;
    logic        awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] d;
    logic        irqAfterTransferSelect = 0, countExhausted = 0, transferBusy = 0;
    logic        transferDone = 0, activationTake = 0, activationReq, swActivationEnable;
    vector_type  swVectorNumber;
    int          err_count = 0, checks_done = 0;

    transfer_sw_activation u_transfer_sw_activation (
        .mclk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .irqAfterTransferSelect, .countExhausted, .transferBusy, .transferDone,
        .activationTake, .activationReq, .swActivationEnable, .swVectorNumber
    );

    // Free-running 250 MHz clock
    initial begin
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Counts: %0d checks, %0d mismatches", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Write one word, wait for the response under a bound
    task automatic wr(input logic [17:0] a, input logic [31:0] v, input logic [3:0] s);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 40);
        if (!bvalid) begin
            chk("bvalid", 0, 1);
            finish_test();
        end
        r = bresp;
    endtask

    // Read one word, wait for the data under a bound
    task automatic rd(input logic [17:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 40);
        if (!rvalid) begin
            chk("rvalid", 0, 1);
            finish_test();
        end
        d = rdata;
        r = rresp;
    endtask

    // One-cycle pulse: 0 transfer end, 1 request take
    task automatic pulse(input int which);
        if (which == 0) transferDone <= 1'b1;
        else activationTake <= 1'b1;
        @(posedge mclk);
        transferDone <= 1'b0;
        activationTake <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic t_reset();
        rd(VEC);
        chk("reset word", d, 32'h0000_0000);
        chk("reset req", activationReq, 0);
        $display("done: reset");
    endtask

    task automatic t_set();
        wr(VEC, 32'h0000_0085, 4'hF);
        chk("enable", swActivationEnable, 1);
        chk("vector", swVectorNumber, 5);
        chk("req", activationReq, 1);
        rd(VEC);
        chk("readback", d, 32'h0000_0085);
        pulse(1);
        chk("req taken", activationReq, 0);
        wr(VEC, 32'h0000_0086, 4'hF);
        chk("no new req", activationReq, 0);
        chk("enable kept", swActivationEnable, 1);
        $display("done: set");
    endtask

    task automatic t_clear();
        wr(VEC, 32'h0000_0006, 4'hF);
        chk("clear unread", swActivationEnable, 1);
        rd(VEC);
        wr(VEC, 32'h0000_0006, 4'hF);
        chk("clear read", swActivationEnable, 0);
        wr(VEC, 32'h0000_0080, 4'h0);
        chk("no strobe", swActivationEnable, 0);
        wr(BAD, 32'h0000_0080, 4'hF);
        chk("bad wr resp", r, 2'h2);
        chk("bad wr", swActivationEnable, 0);
        rd(BAD);
        chk("bad rd resp", r, 2'h2);
        chk("bad rd data", d, 32'h0000_0000);
        $display("done: clear");
    endtask

    task automatic t_hw();
        wr(VEC, 32'h0000_0081, 4'hF);
        transferBusy <= 1'b1;
        rd(VEC);
        rd(STAT);
        chk("status busy", d, 32'h0000_0007);
        wr(VEC, 32'h0000_0001, 4'hF);
        chk("busy hold", swActivationEnable, 1);
        transferBusy <= 1'b0;
        irqAfterTransferSelect <= 1'b1;
        pulse(0);
        chk("select hold", swActivationEnable, 1);
        irqAfterTransferSelect <= 1'b0;
        countExhausted <= 1'b1;
        rd(STAT);
        chk("status exhaust", d, 32'h0000_0011);
        pulse(0);
        chk("exhaust hold", swActivationEnable, 1);
        countExhausted <= 1'b0;
        pulse(0);
        chk("hw clear", swActivationEnable, 0);
        chk("vector kept", swVectorNumber, 1);
        $display("done: hardware");
    endtask

    // Reset in mid-run with enable, vector and request all set
    task automatic t_midreset();
        wr(VEC, 32'h0000_0093, 4'hF);
        chk("pre reset req", activationReq, 1);
        chk("pre reset vector", swVectorNumber, 32'h13);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk("rst enable", swActivationEnable, 0);
        chk("rst vector", swVectorNumber, 0);
        chk("rst req", activationReq, 0);
        rd(VEC);
        chk("rst word", d, 32'h0000_0000);
        $display("done: mid reset");
    endtask

    // Reset, then the scenarios in order
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_set();
        t_clear();
        t_hw();
        t_midreset();
        finish_test();
    end
endmodule

`default_nettype wire
